// ==== core/sbp_pkg.sv ====
/*
  Package for the switch buffer manager pacing, default tag and drop
  counter register slice: register numbers, field layout, timing figures
  and the carrier types.
  Assumes one switch core clock; register numbers are used as addresses.
*/
package sbp_pkg;

  // Register port widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // Register numbers
  localparam logic [15:0] ADDR_PACE_P1_Q23 = 16'h1C10;
  localparam logic [15:0] ADDR_PACE_P2_Q01 = 16'h1C11;
  localparam logic [15:0] ADDR_PACE_P2_Q23 = 16'h1C12;
  localparam logic [15:0] ADDR_TAG_HOST    = 16'h1C13;
  localparam logic [15:0] ADDR_TAG_P1      = 16'h1C14;
  localparam logic [15:0] ADDR_TAG_P2      = 16'h1C15;
  localparam logic [15:0] ADDR_DROP_HOST   = 16'h1C16;
  localparam logic [15:0] ADDR_DROP_P1     = 16'h1C17;
  localparam logic [15:0] ADDR_DROP_P2     = 16'h1C18;
  localparam logic [15:0] ADDR_PACE_CTRL   = 16'h1C1F;

  // Pacing field layout
  localparam int RATE_W        = 13;
  localparam int PACE_ODD_LSB  = 13;
  localparam int PACE_EVEN_LSB = 0;
  localparam int NUM_QUEUES    = 6;
  localparam int PACE_EN_BIT   = 0;

  // Default tag field layout
  localparam int PRI_LSB = 12;
  localparam int PRI_W   = 3;
  localparam int VID_LSB = 0;
  localparam int VID_W   = 12;
  localparam int NUM_PORTS = 3;

  // Drop counter
  localparam int CNT_W = 32;
  localparam logic [31:0] CNT_MAX = 32'hFFFF_FFFF;

  // Pacing time base
  localparam int PACE_UNIT_NS  = 20;
  localparam int CLK_FREQ_MHZ  = 40;
  localparam int CLK_PERIOD_NS = 1000 / CLK_FREQ_MHZ;
  localparam int DEBT_W        = 18;

  // Carrier types
  typedef struct packed {
    logic [RATE_W-1:0] odd_q;
    logic [RATE_W-1:0] even_q;
  } sbp_pace_t;

  typedef struct packed {
    logic [PRI_W-1:0] pri;
    logic [VID_W-1:0] vid;
  } sbp_tag_t;

  typedef struct packed {
    logic [PRI_W-1:0] pri;
    logic             dei;
    logic [VID_W-1:0] vid;
  } sbp_tci_t;

endpackage

// ==== core/sbp_pacer.sv ====
/*
  Per-queue egress byte pacer. After each byte it holds off the next one
  for (rate + 1) x 20 ns, counted down in nanoseconds at the core clock.
  Assumes byte_sent and the rate come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sbp_pacer #(
  parameter int RATE_W = sbp_pkg::RATE_W
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // Control
  input  wire logic              pace_en,
  input  wire logic [RATE_W-1:0] rate,
  // Byte stream handshake
  input  wire logic              byte_sent,
  output logic                   byte_ok
);

  localparam logic [sbp_pkg::DEBT_W-1:0] UNIT_NS =
    sbp_pkg::DEBT_W'(sbp_pkg::PACE_UNIT_NS);
  localparam logic [sbp_pkg::DEBT_W-1:0] STEP_NS =
    sbp_pkg::DEBT_W'(sbp_pkg::CLK_PERIOD_NS);

  logic [sbp_pkg::DEBT_W-1:0] debt;
  logic [sbp_pkg::DEBT_W-1:0] next_debt;
  logic [sbp_pkg::DEBT_W-1:0] load_ns;

  // Hold-off after a byte; 13-bit rate x 20 ns fits in 18 bits
  assign load_ns = sbp_pkg::DEBT_W'((sbp_pkg::DEBT_W'(rate) + 1'b1) * UNIT_NS);

  // Fractions of a cycle round up, so the gap is never shorter than asked
  always_comb begin
    if (!pace_en) begin
      next_debt = '0;
    end else if (byte_sent) begin
      next_debt = load_ns;
    end else if (debt > STEP_NS) begin
      next_debt = debt - STEP_NS;
    end else begin
      next_debt = '0;
    end
  end

  // Remaining hold-off time
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      debt <= '0;
    end else begin
      debt <= next_debt;
    end
  end

  // Permission comes from a flop so the egress side sees a clean level
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      byte_ok <= 1'b0;
    end else begin
      byte_ok <= (next_debt == '0);
    end
  end

endmodule
`default_nettype wire

// ==== core/sbp_regs.sv ====
/*
  Buffer manager register slice: egress pacing rates for port 1 queues
  2/3 and port 2 queues 0-3, per-port default VLAN tag values with the
  egress tag builder, and saturating clear-on-read ingress rate drop
  counters for ports 0, 1 and 2.
  Assumes a register port on the core clock with read data one cycle
  after the read strobe, and drop and egress strobes from core logic.
  Assumes the egress side waits for egress_byte_ok before each byte; a
  byte sent while held off restarts the full gap rather than queueing.
  Gaps are rounded up to whole core cycles byte by byte, so a queue never
  runs faster than its rate but may run slightly slower than it.
  Drop events from source port 3 do not exist and are ignored, and a tag
  request for port 3 yields an all-zero tag.
  The pacing enable lives in a small stand-in register of this slice,
  since the shared buffer manager configuration register is elsewhere.
  Reserved bits are not stored at all, so they read zero by construction.
  Read data are zero outside the one cycle after a read strobe.
  Counters saturate and cannot be made to wrap by any sequence of drops.
*/
// Local design decision: the strobed register port.

`timescale 1ns/1ps
`default_nettype none
module sbp_regs #(
  parameter int NUM_QUEUES = sbp_pkg::NUM_QUEUES,
  parameter int NUM_PORTS  = sbp_pkg::NUM_PORTS
) (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  // Register port
  input  wire logic [sbp_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [sbp_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [sbp_pkg::DATA_W-1:0]  reg_rdata,
  // Egress pacing, one bit per queue: p1q2, p1q3, p2q0, p2q1, p2q2, p2q3
  input  wire logic [NUM_QUEUES-1:0]       egress_byte_sent,
  output logic      [NUM_QUEUES-1:0]       egress_byte_ok,
  // Pacing configuration as seen by the rest of the buffer manager
  output logic                             pace_enable,
  output sbp_pkg::sbp_pace_t               pace_p1_q23,
  output sbp_pkg::sbp_pace_t               pace_p2_q01,
  output sbp_pkg::sbp_pace_t               pace_p2_q23,
  // Egress tag builder
  input  wire logic                        tag_req,
  input  wire logic [1:0]                  tag_port,
  output logic                             tag_valid,
  output sbp_pkg::sbp_tci_t                tag_tci,
  // Ingress rate limit drop events
  input  wire logic                        drop_valid,
  input  wire logic [1:0]                  drop_port
);

  // Stored default tags, index is the port number
  sbp_pkg::sbp_tag_t                 dflt_tag [NUM_PORTS];
  logic [sbp_pkg::CNT_W-1:0]         drop_cnt [NUM_PORTS];
  logic [sbp_pkg::CNT_W-1:0]         next_drop_cnt [NUM_PORTS];
  logic [sbp_pkg::DATA_W-1:0]        next_rdata;
  logic [NUM_QUEUES*sbp_pkg::RATE_W-1:0] rate_flat;

  // Saturating increment used by every drop counter
  function automatic logic [sbp_pkg::CNT_W-1:0] sat_inc(
    input logic [sbp_pkg::CNT_W-1:0] v
  );
    if (v == sbp_pkg::CNT_MAX) begin
      return v;
    end
    return v + 1'b1;
  endfunction

  // Pack a pacing register into the 32-bit read word, upper bits zero
  function automatic logic [sbp_pkg::DATA_W-1:0] pace_word(
    input sbp_pkg::sbp_pace_t p
  );
    logic [sbp_pkg::DATA_W-1:0] w;
    w = '0;
    w[sbp_pkg::PACE_ODD_LSB  +: sbp_pkg::RATE_W] = p.odd_q;
    w[sbp_pkg::PACE_EVEN_LSB +: sbp_pkg::RATE_W] = p.even_q;
    return w;
  endfunction

  // Unpack a written word into a pacing register, reserved bits dropped
  function automatic sbp_pkg::sbp_pace_t pace_from(
    input logic [sbp_pkg::DATA_W-1:0] w
  );
    sbp_pkg::sbp_pace_t p;
    p.odd_q  = w[sbp_pkg::PACE_ODD_LSB  +: sbp_pkg::RATE_W];
    p.even_q = w[sbp_pkg::PACE_EVEN_LSB +: sbp_pkg::RATE_W];
    return p;
  endfunction

  // Pack a default tag into the read word, upper bits zero
  function automatic logic [sbp_pkg::DATA_W-1:0] tag_word(
    input sbp_pkg::sbp_tag_t t
  );
    logic [sbp_pkg::DATA_W-1:0] w;
    w = '0;
    w[sbp_pkg::PRI_LSB +: sbp_pkg::PRI_W] = t.pri;
    w[sbp_pkg::VID_LSB +: sbp_pkg::VID_W] = t.vid;
    return w;
  endfunction

  // Unpack a written word into a default tag
  function automatic sbp_pkg::sbp_tag_t tag_from(
    input logic [sbp_pkg::DATA_W-1:0] w
  );
    sbp_pkg::sbp_tag_t t;
    t.pri = w[sbp_pkg::PRI_LSB +: sbp_pkg::PRI_W];
    t.vid = w[sbp_pkg::VID_LSB +: sbp_pkg::VID_W];
    return t;
  endfunction

  // Register number of the default tag of a port
  function automatic logic [sbp_pkg::ADDR_W-1:0] tag_addr(input int p);
    return sbp_pkg::ADDR_TAG_HOST + sbp_pkg::ADDR_W'(p);
  endfunction

  // Register number of the drop counter of a port
  function automatic logic [sbp_pkg::ADDR_W-1:0] cnt_addr(input int p);
    return sbp_pkg::ADDR_DROP_HOST + sbp_pkg::ADDR_W'(p);
  endfunction

  // Strobe aimed at one register number
  function automatic logic hit(
    input logic                       strobe,
    input logic [sbp_pkg::ADDR_W-1:0] addr,
    input logic [sbp_pkg::ADDR_W-1:0] target
  );
    return strobe && addr == target;
  endfunction

  // Drop event from one source port; port 3 never matches a counter
  function automatic logic drop_from(
    input logic       valid,
    input logic [1:0] port,
    input int         p
  );
    return valid && port == 2'(p);
  endfunction

  // Pacing enable; the rates alone never start pacing
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pace_enable <= 1'b0;
    end else if (hit(reg_wr, reg_addr, sbp_pkg::ADDR_PACE_CTRL)) begin
      pace_enable <= reg_wdata[sbp_pkg::PACE_EN_BIT];
    end
  end

  // Pacing rate registers at three consecutive numbers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pace_p1_q23 <= '0;
      pace_p2_q01 <= '0;
      pace_p2_q23 <= '0;
    end else if (reg_wr) begin
      if (reg_addr == sbp_pkg::ADDR_PACE_P1_Q23) begin
        pace_p1_q23 <= pace_from(reg_wdata);
      end
      if (reg_addr == sbp_pkg::ADDR_PACE_P2_Q01) begin
        pace_p2_q01 <= pace_from(reg_wdata);
      end
      if (reg_addr == sbp_pkg::ADDR_PACE_P2_Q23) begin
        pace_p2_q23 <= pace_from(reg_wdata);
      end
    end
  end

  // Default tag registers, one per port
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        dflt_tag[p] <= '0;
      end
    end else if (reg_wr) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (reg_addr == tag_addr(p)) begin
          dflt_tag[p] <= tag_from(reg_wdata);
        end
      end
    end
  end

  // Next counts; a clearing read restarts at one if a drop lands with it
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      next_drop_cnt[p] = drop_cnt[p];
      if (hit(reg_rd, reg_addr, cnt_addr(p))) begin
        if (drop_from(drop_valid, drop_port, p)) begin
          next_drop_cnt[p] = sbp_pkg::CNT_W'(1);
        end else begin
          next_drop_cnt[p] = '0;
        end
      end else if (drop_from(drop_valid, drop_port, p)) begin
        next_drop_cnt[p] = sat_inc(drop_cnt[p]);
      end
    end
  end

  // Drop counters hold their count between events and reads
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        drop_cnt[p] <= '0;
      end
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        drop_cnt[p] <= next_drop_cnt[p];
      end
    end
  end

  // Read mux; unmapped numbers and reserved bits read as zero
  always_comb begin
    next_rdata = '0;
    unique case (reg_addr)
      sbp_pkg::ADDR_PACE_P1_Q23: next_rdata = pace_word(pace_p1_q23);
      sbp_pkg::ADDR_PACE_P2_Q01: next_rdata = pace_word(pace_p2_q01);
      sbp_pkg::ADDR_PACE_P2_Q23: next_rdata = pace_word(pace_p2_q23);
      sbp_pkg::ADDR_TAG_HOST:    next_rdata = tag_word(dflt_tag[0]);
      sbp_pkg::ADDR_TAG_P1:      next_rdata = tag_word(dflt_tag[1]);
      sbp_pkg::ADDR_TAG_P2:      next_rdata = tag_word(dflt_tag[2]);
      sbp_pkg::ADDR_DROP_HOST:   next_rdata = drop_cnt[0];
      sbp_pkg::ADDR_DROP_P1:     next_rdata = drop_cnt[1];
      sbp_pkg::ADDR_DROP_P2:     next_rdata = drop_cnt[2];
      sbp_pkg::ADDR_PACE_CTRL: begin
        next_rdata[sbp_pkg::PACE_EN_BIT] = pace_enable;
      end
      default:                   next_rdata = '0;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= '0;
    end
  end

  // Egress tag builder: priority and VLAN ID from the port default
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tag_valid <= 1'b0;
      tag_tci   <= '0;
    end else begin
      tag_valid <= tag_req;
      if (tag_req) begin
        tag_tci.dei <= 1'b0;
        if (tag_port < 2'(NUM_PORTS)) begin
          tag_tci.pri <= dflt_tag[tag_port].pri;
          tag_tci.vid <= dflt_tag[tag_port].vid;
        end else begin
          tag_tci.pri <= '0;
          tag_tci.vid <= '0;
        end
      end
    end
  end

  // Queue order of the pacers follows the field order in the registers
  assign rate_flat = {pace_p2_q23.odd_q, pace_p2_q23.even_q,
                      pace_p2_q01.odd_q, pace_p2_q01.even_q,
                      pace_p1_q23.odd_q, pace_p1_q23.even_q};

  // One pacer per queue; the shared enable gates them all
  for (genvar q = 0; q < NUM_QUEUES; q++) begin : g_pacer
    sbp_pacer #(
      .RATE_W (sbp_pkg::RATE_W)
    ) u_pacer (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .pace_en   (pace_enable),
      .rate      (rate_flat[q*sbp_pkg::RATE_W +: sbp_pkg::RATE_W]),
      .byte_sent (egress_byte_sent[q]),
      .byte_ok   (egress_byte_ok[q])
    );
  end

endmodule
`default_nettype wire

// ==== testbench/sbp_regs_chk.sv ====
/*
  Port checker for the pacing, default tag and drop counter slice.
  Assumes the single core clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sbp_regs_chk #(
  parameter int NUM_QUEUES = sbp_pkg::NUM_QUEUES,
  parameter int NUM_PORTS  = sbp_pkg::NUM_PORTS
) (
  // Clock and reset
  input wire logic                       clk_sys,
  input wire logic                       sys_rst,
  // Register port
  input wire logic [sbp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic                       reg_rd,
  input wire logic [sbp_pkg::DATA_W-1:0] reg_rdata,
  // Pacing
  input wire logic                       pace_enable,
  input wire logic [NUM_QUEUES-1:0]      egress_byte_sent,
  input wire logic [NUM_QUEUES-1:0]      egress_byte_ok,
  // Tags and drops
  input wire logic                       tag_req,
  input wire logic [1:0]                 tag_port,
  input wire logic                       tag_valid,
  input wire sbp_pkg::sbp_tci_t          tag_tci,
  input wire logic                       drop_valid,
  input wire logic [1:0]                 drop_port
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Host counter read; the race case needs it twice in a row
  logic rd_h;
  assign rd_h = reg_rd && reg_addr == sbp_pkg::ADDR_DROP_HOST;
  property p_rdata_idle; !reg_rd |=> reg_rdata == '0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  property p_pace_rsv;
    reg_rd && reg_addr >= sbp_pkg::ADDR_PACE_P1_Q23 && reg_addr <= sbp_pkg::ADDR_PACE_P2_Q23
      |=> reg_rdata[31:26] == 6'h00;
  endproperty
  a_pace_rsv: assert property (p_pace_rsv) else $error("pacing spare bits set");
  property p_tag_rsv;
    reg_rd && reg_addr >= sbp_pkg::ADDR_TAG_HOST && reg_addr <= sbp_pkg::ADDR_TAG_P2
      |=> reg_rdata[31:15] == 17'h00000;
  endproperty
  a_tag_rsv: assert property (p_tag_rsv) else $error("tag spare bits set");
  property p_rd_clear; rd_h && !drop_valid ##1 rd_h |=> reg_rdata == '0; endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("counter not cleared");
  property p_rd_race; rd_h && drop_valid && drop_port == 2'h0 ##1 rd_h |=> reg_rdata == 32'h00000001; endproperty
  a_rd_race: assert property (p_rd_race) else $error("drop lost at read");
  // Two idle cycles so the registered ready has seen the enable drop
  property p_pace_off; !sys_rst && !pace_enable ##1 !pace_enable |-> &egress_byte_ok; endproperty
  a_pace_off: assert property (p_pace_off) else $error("pacing while off");
  property p_pace_gap;
    pace_enable && |egress_byte_sent |=> (egress_byte_ok & $past(egress_byte_sent)) == '0;
  endproperty
  a_pace_gap: assert property (p_pace_gap) else $error("no gap after byte");
  property p_tag_next; tag_req |=> tag_valid && tag_tci.dei == 1'b0; endproperty
  a_tag_next: assert property (p_tag_next) else $error("tag not answered");
  property p_tag_none; tag_req && tag_port == 2'h3 |=> tag_tci == '0; endproperty
  a_tag_none: assert property (p_tag_none) else $error("tag for no port");
endmodule
bind sbp_regs sbp_regs_chk #(.NUM_QUEUES(NUM_QUEUES), .NUM_PORTS(NUM_PORTS)) sbp_regs_chk_i (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pace_enable(pace_enable), .egress_byte_sent(egress_byte_sent), .egress_byte_ok(egress_byte_ok),
  .tag_req(tag_req), .tag_port(tag_port), .tag_valid(tag_valid), .tag_tci(tag_tci),
  .drop_valid(drop_valid), .drop_port(drop_port));
`default_nettype wire

// ==== testbench/sbp_regs_tb.sv ====
/*
  Self-checking bench for sbp_regs: registers, tags, drop counters, pacing.
  Assumes the bench drives every port; saturation at all ones is out of reach.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module sbp_regs_tb;
  logic               clk_sys = 1'b0;
  logic               sys_rst = 1'b1;
  logic [15:0]        reg_addr = '0;
  logic [31:0]        reg_wdata = '0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [31:0]        reg_rdata;
  logic [5:0]         egress_byte_sent = '0;
  logic [5:0]         egress_byte_ok;
  logic               pace_enable;
  sbp_pkg::sbp_pace_t pace_p1_q23;
  sbp_pkg::sbp_pace_t pace_p2_q01;
  sbp_pkg::sbp_pace_t pace_p2_q23;
  logic               tag_req = 1'b0;
  logic [1:0]         tag_port = '0;
  logic               tag_valid;
  sbp_pkg::sbp_tci_t  tag_tci;
  logic               drop_valid = 1'b0;
  logic [1:0]         drop_port = '0;
  int                 failures = 0;
  int                 total_checks = 0;
  int                 cycles = 0;
  sbp_regs sbp_regs_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .egress_byte_sent(egress_byte_sent),
    .egress_byte_ok(egress_byte_ok), .pace_enable(pace_enable), .pace_p1_q23(pace_p1_q23),
    .pace_p2_q01(pace_p2_q01), .pace_p2_q23(pace_p2_q23), .tag_req(tag_req), .tag_port(tag_port),
    .tag_valid(tag_valid), .tag_tci(tag_tci), .drop_valid(drop_valid), .drop_port(drop_port));
  // 40 MHz core clock
  always #12.5 clk_sys = ~clk_sys;
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Hang guard, far above the two hundred or so cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end
  // One-cycle write, then a low cycle so the strobe is never set twice at once
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Read; data stand only in the cycle after the strobe
  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
    @(posedge clk_sys);
  endtask
  task automatic t_reset();
    for (int a = 'h1C10; a <= 'h1C18; a++) rdc(16'(a), 32'h00000000);
    rdc(sbp_pkg::ADDR_PACE_CTRL, 32'h00000000);
    `CHK(egress_byte_ok, 6'h3F)
    $display("test reset done");
  endtask
  task automatic t_regs();
    for (int k = 0; k < 3; k++) begin
      wr(sbp_pkg::ADDR_PACE_P1_Q23 + 16'(k), 32'hFFFFFFFF);
      rdc(sbp_pkg::ADDR_PACE_P1_Q23 + 16'(k), 32'h03FFFFFF);
      wr(sbp_pkg::ADDR_TAG_HOST + 16'(k), 32'hFFFFFFFF);
      rdc(sbp_pkg::ADDR_TAG_HOST + 16'(k), 32'h00007FFF);
    end
    wr(16'h1C19, 32'hFFFFFFFF);
    rdc(16'h1C19, 32'h00000000);
    `CHK(pace_p1_q23, 26'h3FFFFFF)
    `CHK(pace_p2_q23, 26'h3FFFFFF)
    wr(sbp_pkg::ADDR_PACE_P2_Q01, {6'h00, 13'h1ABC, 13'h0123});
    `CHK(pace_p2_q01.odd_q, 13'h1ABC)
    `CHK(pace_p2_q01.even_q, 13'h0123)
    $display("test regs done");
  endtask
  task automatic t_tag();
    for (int p = 0; p < 3; p++) wr(sbp_pkg::ADDR_TAG_HOST + 16'(p), {17'h0, 3'(p + 5), 12'hA50 + 12'(p)});
    for (int p = 0; p < 4; p++) begin
      tag_req <= 1'b1;
      tag_port <= 2'(p);
      @(posedge clk_sys);
      tag_req <= 1'b0;
      #1;
      `CHK(tag_tci, (p == 3) ? 16'h0000 : {3'(p + 5), 1'b0, 12'hA50 + 12'(p)})
      `CHK(tag_valid, 1'b1)
      @(posedge clk_sys);
    end
    $display("test tag done");
  endtask
  // Per port drop counts; port 3 is not a source and must count nowhere
  task automatic t_drop();
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 3 - p + 2 * (p / 3) * 2; i++) begin
        drop_valid <= 1'b1;
        drop_port <= 2'(p);
        @(posedge clk_sys);
      end
      drop_valid <= 1'b0;
      @(posedge clk_sys);
    end
    rdc(sbp_pkg::ADDR_DROP_HOST, 32'h00000003);
    rdc(sbp_pkg::ADDR_DROP_P1, 32'h00000002);
    rdc(sbp_pkg::ADDR_DROP_P2, 32'h00000001);
    rdc(sbp_pkg::ADDR_DROP_HOST, 32'h00000000);
    reg_addr <= sbp_pkg::ADDR_DROP_HOST;
    reg_rd <= 1'b1;
    drop_valid <= 1'b1;
    drop_port <= 2'h0;
    @(posedge clk_sys);
    drop_valid <= 1'b0;
    #1;
    `CHK(reg_rdata, 32'h00000000)
    @(posedge clk_sys);
    #1;
    `CHK(reg_rdata, 32'h00000001)
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, 32'h00000000)
    @(posedge clk_sys);
    $display("test drop done");
  endtask
  // Count the cycles a queue is held off after one byte
  task automatic gap(input int q, input int n);
    int c;
    c = 0;
    egress_byte_sent[q] <= 1'b1;
    @(posedge clk_sys);
    egress_byte_sent[q] <= 1'b0;
    #1;
    while (egress_byte_ok[q] === 1'b0 && c < 500) begin
      @(posedge clk_sys);
      #1;
      c++;
    end
    `CHK(c, n)
    @(posedge clk_sys);
  endtask
  task automatic t_pace();
    wr(sbp_pkg::ADDR_PACE_CTRL, 32'hFFFFFFFF);
    rdc(sbp_pkg::ADDR_PACE_CTRL, 32'h00000001);
    `CHK(pace_enable, 1'b1)
    for (int k = 0; k < 3; k++) wr(sbp_pkg::ADDR_PACE_P1_Q23 + 16'(k), {6'h00, 13'(2 * k + 3), 13'(2 * k + 2)});
    for (int q = 0; q < 6; q++) gap(q, ((q + 3) * 20 + 24) / 25);
    wr(sbp_pkg::ADDR_PACE_P2_Q23, 32'h00000000);
    gap(4, 1);
    wr(sbp_pkg::ADDR_PACE_CTRL, 32'h00000000);
    egress_byte_sent <= 6'h3F;
    @(posedge clk_sys);
    egress_byte_sent <= 6'h00;
    @(posedge clk_sys);
    #1;
    `CHK(egress_byte_ok, 6'h3F)
    `CHK(pace_enable, 1'b0)
    $display("test pace done");
  endtask
  // Reset in mid-run must bring written registers back to zero
  task automatic t_rerun();
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rdc(sbp_pkg::ADDR_PACE_P2_Q01, 32'h00000000);
    rdc(sbp_pkg::ADDR_TAG_P1, 32'h00000000);
    `CHK(egress_byte_ok, 6'h3F)
    $display("test rerun done");
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_regs();
    t_tag();
    t_drop();
    t_pace();
    t_rerun();
    test_done();
  end
endmodule
`default_nettype wire
